/* File: logic/cpu8_exec_pkg.sv */
package cpu8_exec_pkg;

	// ************************************************************
	// Register file and status word layout
	// ************************************************************
	localparam logic [2:0] REG_X = 3'h0;
	localparam logic [2:0] REG_A = 3'h1;
	localparam logic [2:0] REG_L = 3'h6;
	localparam logic [2:0] REG_H = 3'h7;
	localparam logic [1:0] PAIR_ACC = 2'h0;
	localparam logic [1:0] PAIR_PTR = 2'h3;
	localparam int unsigned STAT_INT_EN = 7;
	localparam int unsigned STAT_ZERO = 6;
	localparam int unsigned STAT_AUX = 4;
	localparam int unsigned STAT_CARRY = 0;
	localparam logic [7:0] STATUS_RESET = 8'h02;

	// ************************************************************
	// Offsets and sequencing constants
	// ************************************************************
	localparam logic [7:0] BYTE_STEP = 8'h01;
	localparam logic [15:0] WORD_STEP = 16'h0001;
	localparam logic [15:0] STACK_ONE = 16'h0001;
	localparam logic [15:0] STACK_TWO = 16'h0002;
	localparam logic [15:0] STACK_THREE = 16'h0003;
	localparam logic [3:0] FIRST_CYCLE = 4'h1;
	localparam logic [3:0] READ_LAG = 4'h2;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [5:0] {
		K_NOP, K_ADD, K_ADD_WITH_CARRY, K_SUB, K_SUBTRACT_BORROW,
		K_AND, K_OR, K_XOR, K_COMPARE, K_WORD_ADD, K_WORD_SUBTRACT,
		K_WORD_COMPARE, K_INC, K_DEC, K_PAIR_INC, K_PAIR_DEC,
		K_ROTATE_RIGHT, K_ROTATE_LEFT, K_ROTATE_RIGHT_CARRY,
		K_ROTATE_LEFT_CARRY, K_BIT_SET, K_BIT_CLEAR, K_CARRY_SET,
		K_CARRY_CLEAR, K_CARRY_INVERT, K_WORD_SWAP, K_CALL,
		K_TABLE_CALL, K_RETURN, K_INTERRUPT_RETURN, K_PUSH_STATUS,
		K_PUSH_PAIR, K_POP_STATUS, K_POP_PAIR, K_BRANCH_AX,
		K_BRANCH_CARRY, K_BRANCH_NO_CARRY, K_BRANCH_ZERO,
		K_BRANCH_NONZERO, K_BRANCH_BIT_SET, K_BRANCH_BIT_CLEAR,
		K_DECREMENT_BRANCH, K_INT_ENABLE, K_INT_DISABLE, K_HALT, K_STOP
	} op_e;

	typedef enum logic [3:0] {
		M_NONE, M_IMM, M_SADDR_IMM, M_REG, M_SADDR, M_ABS, M_PTR,
		M_PTR_OFS, M_SFR, M_ACC, M_STATUS
	} mode_e;

	typedef enum logic [2:0] {
		ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR
	} alu_e;

	typedef struct packed {
		op_e op;
		mode_e mode;
		logic [2:0] reg_sel;
		logic [1:0] pair_sel;
		logic [2:0] bit_sel;
		logic [7:0] disp;
		logic [15:0] imm;
		logic [15:0] addr;
	} instr_s;

	typedef struct packed {
		logic [3:0] bytes;
		logic [3:0] clocks;
	} timing_s;

	typedef struct packed {
		logic req;
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mem_req_s;

	// ************************************************************
	// Decode helpers
	// ************************************************************
	function automatic logic is_alu8(input op_e op);
		return op inside {K_ADD, K_ADD_WITH_CARRY, K_SUB, K_SUBTRACT_BORROW,
			K_AND, K_OR, K_XOR, K_COMPARE};
	endfunction

	function automatic logic is_mem(input mode_e mode);
		return mode inside {M_SADDR_IMM, M_SADDR, M_ABS, M_PTR, M_PTR_OFS,
			M_SFR};
	endfunction

	function automatic timing_s tm(input logic [3:0] b,
		input logic [3:0] c);
		timing_s t;
		t.bytes = b;
		t.clocks = c;
		return t;
	endfunction

	// Length in bytes and duration in CPU clocks
	function automatic timing_s op_timing(input op_e op, input mode_e mode);
		timing_s t;
		t = tm(4'h1, 4'h2);
		if (is_alu8(op)) begin
			case (mode)
				M_SADDR_IMM: t = tm(4'h3, 4'h6);
				M_ABS: t = tm(4'h3, 4'h8);
				M_PTR: t = tm(4'h1, 4'h6);
				M_PTR_OFS: t = tm(4'h2, 4'h6);
				default: t = tm(4'h2, 4'h4);
			endcase
		end else begin
			case (op)
				K_WORD_ADD, K_WORD_SUBTRACT, K_WORD_COMPARE, K_CALL,
				K_INT_ENABLE, K_INT_DISABLE: t = tm(4'h3, 4'h6);
				K_INC, K_DEC: t = tm(4'h2, 4'h4);
				K_PAIR_INC, K_PAIR_DEC, K_PUSH_PAIR, K_POP_STATUS:
					t = tm(4'h1, 4'h4);
				K_BIT_SET, K_BIT_CLEAR: begin
					if (mode == M_ACC) t = tm(4'h2, 4'h4);
					else if (mode == M_PTR) t = tm(4'h2, 4'hA);
					else t = tm(4'h3, 4'h6);
				end
				K_WORD_SWAP, K_TABLE_CALL, K_INTERRUPT_RETURN:
					t = tm(4'h1, 4'h8);
				K_RETURN, K_POP_PAIR, K_BRANCH_AX: t = tm(4'h1, 4'h6);
				K_BRANCH_CARRY, K_BRANCH_NO_CARRY, K_BRANCH_ZERO,
				K_BRANCH_NONZERO: t = tm(4'h2, 4'h6);
				K_BRANCH_BIT_SET, K_BRANCH_BIT_CLEAR:
					t = (mode == M_ACC) ? tm(4'h3, 4'h8) : tm(4'h4, 4'hA);
				K_DECREMENT_BRANCH:
					t = (mode == M_SADDR) ? tm(4'h3, 4'h8) : tm(4'h2, 4'h6);
				default: t = tm(4'h1, 4'h2);
			endcase
		end
		return t;
	endfunction

	function automatic logic [1:0] n_reads(input op_e op, input mode_e mode);
		case (op)
			K_RETURN, K_POP_PAIR, K_TABLE_CALL: return 2'h2;
			K_INTERRUPT_RETURN: return 2'h3;
			K_POP_STATUS: return 2'h1;
			default: return (is_mem(mode) && (is_alu8(op) || op inside {K_INC,
				K_DEC, K_BIT_SET, K_BIT_CLEAR, K_BRANCH_BIT_SET,
				K_BRANCH_BIT_CLEAR, K_DECREMENT_BRANCH})) ? 2'h1 : 2'h0;
		endcase
	endfunction

	function automatic logic [1:0] n_writes(input op_e op, input mode_e mode);
		case (op)
			K_CALL, K_TABLE_CALL, K_PUSH_PAIR: return 2'h2;
			K_PUSH_STATUS: return 2'h1;
			K_COMPARE: return 2'h0;
			K_INC, K_DEC, K_BIT_SET, K_BIT_CLEAR, K_DECREMENT_BRANCH:
				return is_mem(mode) ? 2'h1 : 2'h0;
			default: return (is_alu8(op) && mode == M_SADDR_IMM) ? 2'h1 : 2'h0;
		endcase
	endfunction

endpackage

/* File: logic/cpu8_alu.sv */
`timescale 1ns/1ps
module cpu8_alu (
	// Operation and operands
	input wire cpu8_exec_pkg::alu_e alu_op_i,
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	input wire logic cin_i,
	// Result and flags
	output logic [7:0] res_o,
	output logic zero_o,
	output logic aux_o,
	output logic carry_o
);
	import cpu8_exec_pkg::*;

	logic [8:0] wide;
	logic [4:0] nib;

	always_comb begin
		wide = 9'h000;
		nib = 5'h00;
		aux_o = 1'b0;
		carry_o = 1'b0;
		unique case (alu_op_i)
			ALU_ADD: begin
				wide = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
				nib = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
			end
			ALU_SUB: begin
				// Top bit of the extended difference is the borrow
				wide = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin_i};
				nib = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cin_i};
			end
			ALU_AND: wide = {1'b0, a_i & b_i};
			ALU_OR: wide = {1'b0, a_i | b_i};
			ALU_XOR: wide = {1'b0, a_i ^ b_i};
		endcase
		aux_o = nib[4];
		carry_o = wide[8];
		res_o = wide[7:0];
		zero_o = (wide[7:0] == 8'h00);
	end

endmodule

/* File: logic/cpu8_exec.sv */
`timescale 1ns/1ps
module cpu8_exec #(
	parameter logic [15:0] PC_RESET = 16'h0000,
	parameter logic [15:0] STACK_RESET = 16'hFF00
) (
	// Clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	// Instruction hand-off
	input wire logic START_I,
	input wire cpu8_exec_pkg::instr_s INSTR_I,
	output logic READY_O,
	output logic DONE_O,
	// Data memory port
	output cpu8_exec_pkg::mem_req_s MEM_O,
	input wire logic [7:0] MEM_RDATA_I,
	// Interrupt service state
	input wire logic NMI_ENTER_I,
	output logic NMI_IN_SERVICE_O,
	// Standby
	input wire logic WAKE_I,
	output logic HALT_O,
	output logic STOP_O,
	// Architectural state
	output logic [15:0] PROG_COUNTER_O,
	output logic [15:0] STACK_POINTER_O,
	output logic [7:0] STATUS_WORD_O,
	output logic [7:0][7:0] REGS_O
);
	import cpu8_exec_pkg::*;

	typedef enum logic [1:0] {S_IDLE, S_RUN, S_HALT, S_STOP} state_e;

	// ************************************************************
	// State
	// ************************************************************
	state_e state_r, state_nxt;
	instr_s ins_r, ins_nxt;
	timing_s tim_r, tim_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0][7:0] regs_r, regs_nxt;
	logic [7:0] stat_r, stat_nxt;
	logic [15:0] program_counter_r, program_counter_nxt;
	logic [15:0] stack_pointer_r, stack_pointer_nxt;
	logic [15:0] rbase_r, rbase_nxt, waddr_r, waddr_nxt;
	logic [2:0][7:0] rbuf_r, rbuf_nxt;
	logic [1:0][7:0] wdat_r, wdat_nxt;
	logic nmi_in_service_flag_r, nmi_in_service_flag_nxt, nmi_in_service_flag_clr;
	logic ready_r, ready_nxt, done_r, done_nxt;
	logic halt_r, halt_nxt, stop_r, stop_nxt;
	mem_req_s mem_r, mem_nxt;

	// ************************************************************
	// Working values
	// ************************************************************
	alu_e alu_op;
	logic [7:0] alu_a, alu_b, alu_res, opnd8, bit_src, bit_new;
	logic alu_cin, alu_zero, alu_aux, alu_carry, bit_val;
	logic [16:0] word_res;
	logic [4:0] nib5;
	logic [15:0] acc_pair, sel_pair, pc_seq, pc_rel, ret_addr;
	logic [3:0] exec_at, cap_idx, slot, exec_n;
	logic [1:0] rd_n, wr_n;

	function automatic logic [15:0] pair_get(input logic [7:0][7:0] r,
		input logic [1:0] p);
		return {r[{p, 1'b1}], r[{p, 1'b0}]};
	endfunction

	// Operand data are complete two cycles after the last read
	function automatic logic [3:0] exec_cycle(input logic [1:0] nrd);
		return (nrd == 2'h0) ? FIRST_CYCLE : {2'b00, nrd} + READ_LAG;
	endfunction

	cpu8_alu u_alu (
		.alu_op_i(alu_op),
		.a_i(alu_a),
		.b_i(alu_b),
		.cin_i(alu_cin),
		.res_o(alu_res),
		.zero_o(alu_zero),
		.aux_o(alu_aux),
		.carry_o(alu_carry)
	);

	// ************************************************************
	// Operand selection
	// ************************************************************
	always_comb begin
		opnd8 = (ins_r.mode == M_REG) ? regs_r[ins_r.reg_sel] : rbuf_r[0];
		alu_a = (ins_r.mode == M_SADDR_IMM) ? rbuf_r[0] : regs_r[REG_A];
		alu_b = rbuf_r[0];
		if (ins_r.mode inside {M_IMM, M_SADDR_IMM})
			alu_b = ins_r.imm[7:0];
		else if (ins_r.mode == M_REG)
			alu_b = regs_r[ins_r.reg_sel];
		alu_cin = 1'b0;
		alu_op = ALU_ADD;
		case (ins_r.op)
			K_ADD_WITH_CARRY: alu_cin = stat_r[STAT_CARRY];
			K_SUB, K_COMPARE: alu_op = ALU_SUB;
			K_SUBTRACT_BORROW: begin
				alu_op = ALU_SUB;
				alu_cin = stat_r[STAT_CARRY];
			end
			K_AND: alu_op = ALU_AND;
			K_OR: alu_op = ALU_OR;
			K_XOR: alu_op = ALU_XOR;
			K_INC, K_DEC, K_DECREMENT_BRANCH: begin
				alu_a = opnd8;
				alu_b = BYTE_STEP;
				alu_op = (ins_r.op == K_INC) ? ALU_ADD : ALU_SUB;
			end
			default: ;
		endcase
		acc_pair = pair_get(regs_r, PAIR_ACC);
		sel_pair = pair_get(regs_r, ins_r.pair_sel);
		pc_seq = program_counter_r + {12'h000, tim_r.bytes};
		pc_rel = pc_seq + {{8{ins_r.disp[7]}}, ins_r.disp};
		ret_addr = pc_seq;
		if (ins_r.op == K_WORD_ADD) begin
			word_res = {1'b0, acc_pair} + {1'b0, ins_r.imm};
			nib5 = {1'b0, acc_pair[3:0]} + {1'b0, ins_r.imm[3:0]};
		end else begin
			word_res = {1'b0, acc_pair} - {1'b0, ins_r.imm};
			nib5 = {1'b0, acc_pair[3:0]} - {1'b0, ins_r.imm[3:0]};
		end
		if (ins_r.mode == M_ACC)
			bit_src = regs_r[REG_A];
		else if (ins_r.mode == M_STATUS)
			bit_src = stat_r;
		else
			bit_src = rbuf_r[0];
		bit_val = bit_src[ins_r.bit_sel];
		bit_new = (ins_r.op == K_BIT_SET) ?
			(bit_src | (BYTE_STEP << ins_r.bit_sel)) :
			(bit_src & ~(BYTE_STEP << ins_r.bit_sel));
	end

	// ************************************************************
	// Sequencer and execution
	// ************************************************************
	always_comb begin
		state_nxt = state_r;
		ins_nxt = ins_r;
		tim_nxt = tim_r;
		cnt_nxt = cnt_r;
		regs_nxt = regs_r;
		stat_nxt = stat_r;
		program_counter_nxt = program_counter_r;
		stack_pointer_nxt = stack_pointer_r;
		rbase_nxt = rbase_r;
		waddr_nxt = waddr_r;
		wdat_nxt = wdat_r;
		rbuf_nxt = rbuf_r;
		nmi_in_service_flag_clr = 1'b0;
		exec_at = exec_cycle(n_reads(ins_r.op, ins_r.mode));
		cap_idx = cnt_r - READ_LAG;
		if (state_r == S_RUN) begin
			cnt_nxt = cnt_r + FIRST_CYCLE;
			if (cnt_r >= READ_LAG && cnt_r < exec_at)
				rbuf_nxt[cap_idx[1:0]] = MEM_RDATA_I;
			if (cnt_r == exec_at) begin
				program_counter_nxt = pc_seq;
				case (ins_r.op)
					K_ADD, K_ADD_WITH_CARRY, K_SUB, K_SUBTRACT_BORROW, K_COMPARE,
					K_AND, K_OR, K_XOR: begin
						stat_nxt[STAT_ZERO] = alu_zero;
						if (!(ins_r.op inside {K_AND, K_OR, K_XOR})) begin
							stat_nxt[STAT_AUX] = alu_aux;
							stat_nxt[STAT_CARRY] = alu_carry;
						end
						if (ins_r.op != K_COMPARE) begin
							if (ins_r.mode == M_SADDR_IMM) begin
								waddr_nxt = rbase_r;
								wdat_nxt[0] = alu_res;
							end else
								regs_nxt[REG_A] = alu_res;
						end
					end
					K_WORD_ADD, K_WORD_SUBTRACT, K_WORD_COMPARE: begin
						stat_nxt[STAT_ZERO] = (word_res[15:0] == 16'h0000);
						stat_nxt[STAT_AUX] = nib5[4];
						if (ins_r.op != K_WORD_COMPARE) begin
							stat_nxt[STAT_CARRY] = word_res[16];
							{regs_nxt[REG_A], regs_nxt[REG_X]} = word_res[15:0];
						end
					end
					K_INC, K_DEC: begin
						stat_nxt[STAT_ZERO] = alu_zero;
						stat_nxt[STAT_AUX] = alu_aux;
						if (ins_r.mode == M_REG)
							regs_nxt[ins_r.reg_sel] = alu_res;
						else begin
							waddr_nxt = rbase_r;
							wdat_nxt[0] = alu_res;
						end
					end
					K_PAIR_INC, K_PAIR_DEC: begin
						{regs_nxt[{ins_r.pair_sel, 1'b1}],
							regs_nxt[{ins_r.pair_sel, 1'b0}]} =
							(ins_r.op == K_PAIR_INC) ? sel_pair + WORD_STEP :
							sel_pair - WORD_STEP;
					end
					K_ROTATE_RIGHT, K_ROTATE_RIGHT_CARRY: begin
						stat_nxt[STAT_CARRY] = regs_r[REG_A][0];
						regs_nxt[REG_A] = {(ins_r.op == K_ROTATE_RIGHT) ?
							regs_r[REG_A][0] : stat_r[STAT_CARRY],
							regs_r[REG_A][7:1]};
					end
					K_ROTATE_LEFT, K_ROTATE_LEFT_CARRY: begin
						stat_nxt[STAT_CARRY] = regs_r[REG_A][7];
						regs_nxt[REG_A] = {regs_r[REG_A][6:0],
							(ins_r.op == K_ROTATE_LEFT) ?
							regs_r[REG_A][7] : stat_r[STAT_CARRY]};
					end
					K_BIT_SET, K_BIT_CLEAR: begin
						if (ins_r.mode == M_ACC)
							regs_nxt[REG_A] = bit_new;
						else if (ins_r.mode == M_STATUS)
							stat_nxt = bit_new;
						else begin
							waddr_nxt = rbase_r;
							wdat_nxt[0] = bit_new;
						end
					end
					K_CARRY_SET: stat_nxt[STAT_CARRY] = 1'b1;
					K_CARRY_CLEAR: stat_nxt[STAT_CARRY] = 1'b0;
					K_CARRY_INVERT: stat_nxt[STAT_CARRY] = ~stat_r[STAT_CARRY];
					K_WORD_SWAP: begin
						{regs_nxt[REG_A], regs_nxt[REG_X]} = sel_pair;
						{regs_nxt[{ins_r.pair_sel, 1'b1}],
							regs_nxt[{ins_r.pair_sel, 1'b0}]} = acc_pair;
					end
					K_CALL, K_TABLE_CALL, K_PUSH_PAIR, K_PUSH_STATUS: begin
						// High byte lands at the upper address, low below it
						waddr_nxt = stack_pointer_r - STACK_ONE;
						wdat_nxt[0] = ret_addr[15:8];
						wdat_nxt[1] = ret_addr[7:0];
						stack_pointer_nxt = stack_pointer_r - STACK_TWO;
						if (ins_r.op == K_CALL)
							program_counter_nxt = ins_r.addr;
						if (ins_r.op == K_TABLE_CALL)
							program_counter_nxt = {rbuf_r[1], rbuf_r[0]};
						if (ins_r.op == K_PUSH_PAIR)
							wdat_nxt = {sel_pair[7:0], sel_pair[15:8]};
						if (ins_r.op == K_PUSH_STATUS) begin
							wdat_nxt[0] = stat_r;
							stack_pointer_nxt = stack_pointer_r - STACK_ONE;
						end
					end
					K_RETURN, K_INTERRUPT_RETURN: begin
						program_counter_nxt = {rbuf_r[1], rbuf_r[0]};
						stack_pointer_nxt = stack_pointer_r + STACK_TWO;
						if (ins_r.op == K_INTERRUPT_RETURN) begin
							stat_nxt = rbuf_r[2];
							stack_pointer_nxt = stack_pointer_r + STACK_THREE;
							nmi_in_service_flag_clr = 1'b1;
						end
					end
					K_POP_STATUS: begin
						stat_nxt = rbuf_r[0];
						stack_pointer_nxt = stack_pointer_r + STACK_ONE;
					end
					K_POP_PAIR: begin
						{regs_nxt[{ins_r.pair_sel, 1'b1}],
							regs_nxt[{ins_r.pair_sel, 1'b0}]} =
							{rbuf_r[1], rbuf_r[0]};
						stack_pointer_nxt = stack_pointer_r + STACK_TWO;
					end
					K_BRANCH_AX:
						program_counter_nxt = {regs_r[REG_A], regs_r[REG_X]};
					K_BRANCH_CARRY: if (stat_r[STAT_CARRY])
						program_counter_nxt = pc_rel;
					K_BRANCH_NO_CARRY: if (!stat_r[STAT_CARRY])
						program_counter_nxt = pc_rel;
					K_BRANCH_ZERO: if (stat_r[STAT_ZERO])
						program_counter_nxt = pc_rel;
					K_BRANCH_NONZERO: if (!stat_r[STAT_ZERO])
						program_counter_nxt = pc_rel;
					K_BRANCH_BIT_SET, K_BRANCH_BIT_CLEAR:
						if (bit_val == (ins_r.op == K_BRANCH_BIT_SET))
							program_counter_nxt = pc_rel;
					K_DECREMENT_BRANCH: begin
						if (ins_r.mode == M_REG)
							regs_nxt[ins_r.reg_sel] = alu_res;
						else begin
							waddr_nxt = rbase_r;
							wdat_nxt[0] = alu_res;
						end
						if (!alu_zero)
							program_counter_nxt = pc_rel;
					end
					K_INT_ENABLE: stat_nxt[STAT_INT_EN] = 1'b1;
					K_INT_DISABLE: stat_nxt[STAT_INT_EN] = 1'b0;
					default: ;
				endcase
			end
			if (cnt_r == tim_r.clocks) begin
				if (ins_r.op == K_HALT)
					state_nxt = S_HALT;
				else if (ins_r.op == K_STOP)
					state_nxt = S_STOP;
				else
					state_nxt = S_IDLE;
			end
		end
		if ((state_r == S_HALT || state_r == S_STOP) && WAKE_I)
			state_nxt = S_IDLE;
		if (START_I && ready_r) begin
			state_nxt = S_RUN;
			ins_nxt = INSTR_I;
			tim_nxt = op_timing(INSTR_I.op, INSTR_I.mode);
			cnt_nxt = FIRST_CYCLE;
			if (INSTR_I.op inside {K_RETURN, K_INTERRUPT_RETURN, K_POP_STATUS,
				K_POP_PAIR})
				rbase_nxt = stack_pointer_nxt;
			else if (INSTR_I.mode == M_PTR)
				rbase_nxt = pair_get(regs_nxt, PAIR_PTR);
			else if (INSTR_I.mode == M_PTR_OFS)
				rbase_nxt = pair_get(regs_nxt, PAIR_PTR) +
					{8'h00, INSTR_I.imm[7:0]};
			else
				rbase_nxt = INSTR_I.addr;
		end
		// Entry wins over a clearing return in the same cycle
		nmi_in_service_flag_nxt = (nmi_in_service_flag_r & ~nmi_in_service_flag_clr) | NMI_ENTER_I;
		done_nxt = (state_nxt == S_RUN) && (cnt_nxt == tim_nxt.clocks);
		ready_nxt = (state_nxt == S_IDLE) || (done_nxt &&
			!(ins_nxt.op inside {K_HALT, K_STOP}));
		halt_nxt = (state_nxt == S_HALT);
		stop_nxt = (state_nxt == S_STOP);
		// Memory slot for the coming cycle: reads first, writes after exec
		rd_n = n_reads(ins_nxt.op, ins_nxt.mode);
		wr_n = n_writes(ins_nxt.op, ins_nxt.mode);
		exec_n = exec_cycle(rd_n);
		slot = cnt_nxt - exec_n - FIRST_CYCLE;
		mem_nxt = '0;
		if (state_nxt == S_RUN) begin
			if (cnt_nxt <= {2'b00, rd_n}) begin
				mem_nxt.req = 1'b1;
				mem_nxt.addr = rbase_nxt + {12'h000, cnt_nxt - FIRST_CYCLE};
			end else if (cnt_nxt > exec_n &&
				cnt_nxt <= exec_n + {2'b00, wr_n}) begin
				mem_nxt.req = 1'b1;
				mem_nxt.we = 1'b1;
				mem_nxt.addr = waddr_nxt - {15'h0000, slot[0]};
				mem_nxt.wdata = wdat_nxt[slot[0]];
			end
		end
	end

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			state_r <= S_IDLE;
			ins_r <= '0;
			tim_r <= '0;
			cnt_r <= '0;
			regs_r <= '0;
			stat_r <= STATUS_RESET;
			program_counter_r <= PC_RESET;
			stack_pointer_r <= STACK_RESET;
			rbase_r <= '0;
			waddr_r <= '0;
			wdat_r <= '0;
			rbuf_r <= '0;
			nmi_in_service_flag_r <= 1'b0;
			ready_r <= 1'b1;
			done_r <= 1'b0;
			halt_r <= 1'b0;
			stop_r <= 1'b0;
			mem_r <= '0;
		end else begin
			state_r <= state_nxt;
			ins_r <= ins_nxt;
			tim_r <= tim_nxt;
			cnt_r <= cnt_nxt;
			regs_r <= regs_nxt;
			stat_r <= stat_nxt;
			program_counter_r <= program_counter_nxt;
			stack_pointer_r <= stack_pointer_nxt;
			rbase_r <= rbase_nxt;
			waddr_r <= waddr_nxt;
			wdat_r <= wdat_nxt;
			rbuf_r <= rbuf_nxt;
			nmi_in_service_flag_r <= nmi_in_service_flag_nxt;
			ready_r <= ready_nxt;
			done_r <= done_nxt;
			halt_r <= halt_nxt;
			stop_r <= stop_nxt;
			mem_r <= mem_nxt;
		end
	end

	assign READY_O = ready_r;
	assign DONE_O = done_r;
	assign MEM_O = mem_r;
	assign NMI_IN_SERVICE_O = nmi_in_service_flag_r;
	assign HALT_O = halt_r;
	assign STOP_O = stop_r;
	assign PROG_COUNTER_O = program_counter_r;
	assign STACK_POINTER_O = stack_pointer_r;
	assign STATUS_WORD_O = stat_r;
	assign REGS_O = regs_r;

endmodule

/* File: bench/cpu8_exec_checker.sv */
`timescale 1ns/1ps
module cpu8_exec_checker
	import cpu8_exec_pkg::*;
(
	// Clock, reset, request
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	input wire logic START_I,
	input wire cpu8_exec_pkg::instr_s INSTR_I,
	// Observed state
	input wire logic READY_O,
	input wire logic DONE_O,
	input wire logic HALT_O,
	input wire logic [15:0] PROG_COUNTER_O,
	input wire logic [15:0] STACK_POINTER_O,
	input wire logic [7:0] STATUS_WORD_O,
	input wire logic [7:0][7:0] REGS_O
);
	logic go, imm;
	op_e op;
	logic [15:0] sp;
	logic [7:0] st, acc;
	assign go = START_I && READY_O;
	assign op = INSTR_I.op;
	assign imm = INSTR_I.mode == M_IMM;
	assign sp = STACK_POINTER_O;
	assign st = STATUS_WORD_O;
	assign acc = REGS_O[REG_A];
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);
	property p_busy; go |=> !READY_O; endproperty
	a_busy: assert property (p_busy) else $error("ready while busy");
	property p_add; go && op == K_ADD && imm |=> !DONE_O[*3] ##1 DONE_O;
	endproperty
	a_add: assert property (p_add) else $error("add timing");
	property p_xor; go && op == K_XOR && imm |-> ##4
		st[4] == $past(st[4], 4) && st[0] == $past(st[0], 4); endproperty
	a_xor: assert property (p_xor) else $error("logic op flags");
	property p_rotate_left_carry_op; go && op == K_ROTATE_LEFT_CARRY |-> ##2
		acc == {$past(acc[6:0], 2), $past(st[0], 2)} &&
		st[0] == $past(acc[7], 2); endproperty
	a_rotate_left_carry_op: assert property (p_rotate_left_carry_op) else $error("rotate carry");
	property p_call; go && op == K_CALL |-> ##6 DONE_O &&
		PROG_COUNTER_O == $past(INSTR_I.addr, 6) &&
		sp == $past(sp, 6) - 16'h0002; endproperty
	a_call: assert property (p_call) else $error("call");
	property p_ret; go && op == K_RETURN |-> ##6 DONE_O &&
		sp == $past(sp, 6) + 16'h0002; endproperty
	a_ret: assert property (p_ret) else $error("return");
	property p_push; go && op == K_PUSH_STATUS |-> ##2 DONE_O &&
		sp == $past(sp, 2) - 16'h0001; endproperty
	a_push: assert property (p_push) else $error("push status");
	property p_ei; go && op == K_INT_ENABLE |-> ##6 DONE_O && st[7];
	endproperty
	a_ei: assert property (p_ei) else $error("int enable");
	property p_halt; go && op == K_HALT |-> ##2 DONE_O ##1 HALT_O && !READY_O;
	endproperty
	a_halt: assert property (p_halt) else $error("halt entry");
endmodule
bind cpu8_exec cpu8_exec_checker i_cpu8_exec_checker (.CLK_SYS_I, .RST_I,
	.START_I, .INSTR_I, .READY_O, .DONE_O, .HALT_O, .PROG_COUNTER_O,
	.STACK_POINTER_O, .STATUS_WORD_O, .REGS_O);

/* File: bench/cpu8_mem_model.sv */
`timescale 1ns/1ps
module cpu8_mem_model
	import cpu8_exec_pkg::*;
(
	input wire logic clk_i,
	input wire cpu8_exec_pkg::mem_req_s mem_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [0:65535];
	initial rdata_o = 8'h00;
	// Idle bus toggles so a late capture never sees stale data
	always @(posedge clk_i) begin
		if (mem_i.req && mem_i.we) mem[mem_i.addr] <= mem_i.wdata;
		rdata_o <= (mem_i.req && !mem_i.we) ? mem[mem_i.addr] : ~rdata_o;
	end
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import cpu8_exec_pkg::*;
	logic CLK_SYS_I = 1'b0, RST_I = 1'b1, START_I = 1'b0;
	logic NMI_ENTER_I = 1'b0, WAKE_I = 1'b0;
	instr_s INSTR_I = '0;
	logic READY_O, DONE_O, NMI_IN_SERVICE_O, HALT_O, STOP_O;
	mem_req_s MEM_O;
	logic [7:0] MEM_RDATA_I, STATUS_WORD_O;
	logic [15:0] PROG_COUNTER_O, STACK_POINTER_O, a_st;
	logic [7:0][7:0] REGS_O;
	int fail_count = 0, n_tests = 0, cyc = 0;
	assign a_st = {REGS_O[REG_A], STATUS_WORD_O};
	always #12.5 CLK_SYS_I = ~CLK_SYS_I;
	cpu8_exec i_cpu8_exec (.CLK_SYS_I, .RST_I, .START_I, .INSTR_I, .READY_O,
		.DONE_O, .MEM_O, .MEM_RDATA_I, .NMI_ENTER_I, .NMI_IN_SERVICE_O,
		.WAKE_I, .HALT_O, .STOP_O, .PROG_COUNTER_O, .STACK_POINTER_O,
		.STATUS_WORD_O, .REGS_O);
	cpu8_mem_model i_cpu8_mem_model (.clk_i(CLK_SYS_I), .mem_i(MEM_O),
		.rdata_o(MEM_RDATA_I));
	task automatic test_done;
		$display("mismatches %0d checks %0d", fail_count, n_tests);
		if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic run(input op_e o, input mode_e m, input logic [15:0] v,
		input logic [2:0] r);
		int n;
		INSTR_I = '{op: o, mode: m, reg_sel: r, pair_sel: r[1:0], bit_sel: r,
			disp: v[7:0], imm: v, addr: v};
		START_I = 1'b1;
		@(negedge CLK_SYS_I);
		START_I = 1'b0;
		n = 0;
		while (DONE_O !== 1'b1 && n < 20) begin
			@(negedge CLK_SYS_I);
			n++;
		end
	endtask
	task automatic t_alu;
		run(K_ADD, M_IMM, 16'h00F8, 3'h0);
		chk(a_st, 16'hF802);
		run(K_ADD, M_IMM, 16'h0009, 3'h0);
		chk(a_st, 16'h0113);
		run(K_ADD_WITH_CARRY, M_IMM, 16'h0000, 3'h0);
		chk(a_st, 16'h0202);
		run(K_SUB, M_IMM, 16'h0003, 3'h0);
		chk(a_st, 16'hFF13);
		run(K_XOR, M_IMM, 16'h00FF, 3'h0);
		chk(a_st, 16'h0053);
		$display("t_alu done");
	endtask
	task automatic t_mem;
		i_cpu8_mem_model.mem[16'hFE20] = 8'h7F;
		run(K_ADD, M_SADDR_IMM, 16'hFE20, 3'h0);
		chk({i_cpu8_mem_model.mem[16'hFE20], STATUS_WORD_O}, 16'h9F02);
		$display("t_mem done");
	endtask
	task automatic t_stack;
		run(K_CALL, M_NONE, 16'h1234, 3'h0);
		chk(PROG_COUNTER_O, 16'h1234);
		chk({i_cpu8_mem_model.mem[16'hFEFF], i_cpu8_mem_model.mem[16'hFEFE]},
			16'h0010);
		run(K_RETURN, M_NONE, 16'h0000, 3'h0);
		chk(PROG_COUNTER_O ^ STACK_POINTER_O, 16'hFF10);
		run(K_INT_ENABLE, M_NONE, 16'h0000, 3'h0);
		run(K_PUSH_STATUS, M_NONE, 16'h0000, 3'h0);
		chk(STACK_POINTER_O, 16'hFEFF);
		// Push lands in memory only as its last cycle closes
		@(negedge CLK_SYS_I);
		chk({i_cpu8_mem_model.mem[16'hFEFF], STATUS_WORD_O}, 16'h8282);
		$display("t_stack done");
	endtask
	task automatic t_rot;
		run(K_OR, M_IMM, 16'h0081, 3'h0);
		run(K_ROTATE_LEFT_CARRY, M_NONE, 16'h0000, 3'h0);
		chk(a_st, 16'h0283);
		run(K_ROTATE_LEFT_CARRY, M_NONE, 16'h0000, 3'h0);
		chk(a_st, 16'h0582);
		run(K_DECREMENT_BRANCH, M_REG, 16'h0010, 3'h3);
		chk({REGS_O[3], PROG_COUNTER_O[7:0]}, 16'hFF2A);
		$display("t_rot done");
	endtask
	task automatic t_halt;
		run(K_HALT, M_NONE, 16'h0000, 3'h0);
		@(negedge CLK_SYS_I);
		chk({14'h0, HALT_O, READY_O}, 16'h0002);
		WAKE_I = 1'b1;
		@(negedge CLK_SYS_I);
		WAKE_I = 1'b0;
		repeat (2) @(negedge CLK_SYS_I);
		chk({14'h0, HALT_O, READY_O}, 16'h0001);
		$display("t_halt done");
	endtask
	task automatic t_nmi;
		NMI_ENTER_I = 1'b1;
		@(negedge CLK_SYS_I);
		NMI_ENTER_I = 1'b0;
		chk({15'h0000, NMI_IN_SERVICE_O}, 16'h0001);
		run(K_PUSH_PAIR, M_NONE, 16'h0000, 3'h1);
		chk({i_cpu8_mem_model.mem[16'hFEFE], i_cpu8_mem_model.mem[16'hFEFD]},
			16'hFF00);
		run(K_CARRY_SET, M_NONE, 16'h0000, 3'h0);
		run(K_INTERRUPT_RETURN, M_NONE, 16'h0000, 3'h0);
		chk(PROG_COUNTER_O, 16'hFF00);
		chk(STACK_POINTER_O, 16'hFF00);
		chk({STATUS_WORD_O, 7'h00, NMI_IN_SERVICE_O}, 16'h8200);
		run(K_WORD_SWAP, M_NONE, 16'h0000, 3'h1);
		chk({REGS_O[REG_A], REGS_O[3]}, 16'hFF05);
		run(K_COMPARE, M_IMM, 16'h00FF, 3'h0);
		chk(a_st, 16'hFFC2);
		run(K_STOP, M_NONE, 16'h0000, 3'h0);
		@(negedge CLK_SYS_I);
		chk({14'h0000, STOP_O, READY_O}, 16'h0002);
		WAKE_I = 1'b1;
		@(negedge CLK_SYS_I);
		WAKE_I = 1'b0;
		@(negedge CLK_SYS_I);
		chk({14'h0000, STOP_O, READY_O}, 16'h0001);
		$display("t_nmi done");
	endtask
	always @(posedge CLK_SYS_I) begin
		cyc++;
		if (cyc == 2000) begin
			fail_count++;
			test_done;
		end
	end
	initial begin
		repeat (8) @(negedge CLK_SYS_I);
		RST_I = 1'b0;
		t_alu;
		t_mem;
		t_stack;
		t_rot;
		t_halt;
		t_nmi;
		test_done;
	end
endmodule
